// ==== core/element_pkg.sv ====
// Package with constants and types of the protection element comparator
package element_pkg;

	// ***************************************************************
	// Widths and counts
	// ***************************************************************
	localparam int MAG_W = 16;
	localparam int RATIO_W = 16;
	localparam int TIME_W = 16;
	localparam int GROUP_COUNT = 6;
	localparam int GROUP_SEL_W = 3;

	// ***************************************************************
	// Reset values, fallback group and count step
	// ***************************************************************
	localparam logic [TIME_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [GROUP_SEL_W-1:0] FIRST_GROUP = 3'h0;
	localparam logic [TIME_W-1:0] COUNT_STEP = 16'h0001;

	// ***************************************************************
	// Enumerations
	// ***************************************************************
	typedef enum logic [1:0]
	{
		TARGET_DISABLED = 2'b00,
		TARGET_SELF_RESET = 2'b01,
		TARGET_LATCHED = 2'b10
	} target_mode_e;

	typedef enum logic [1:0]
	{
		QTY_PHASE_CURRENT = 2'b00,
		QTY_GROUND_CURRENT = 2'b01,
		QTY_PHASE_VOLTAGE = 2'b10,
		QTY_AUX_VOLTAGE = 2'b11
	} quantity_e;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_PICKUP = 2'b01,
		ST_OPERATE = 2'b10,
		ST_HOLD = 2'b11
	} element_state_e;

	// ***************************************************************
	// Carriers
	// ***************************************************************
	typedef struct packed
	{
		logic [MAG_W-1:0] bank_a_current;
		logic [MAG_W-1:0] bank_b_current;
		logic [MAG_W-1:0] ground_current;
		logic [MAG_W-1:0] phase_voltage;
		logic [MAG_W-1:0] aux_voltage;
	} measurement_s;

	typedef struct packed
	{
		logic use_bank_a;
		logic use_bank_b;
		logic use_ground;
		logic use_phase_voltage;
		logic use_aux_voltage;
		logic [RATIO_W-1:0] bank_a_ratio;
		logic [RATIO_W-1:0] bank_b_ratio;
		quantity_e quantity;
	} source_s;

	typedef struct packed
	{
		logic under_mode;
		logic [MAG_W-1:0] pickup;
		logic [TIME_W-1:0] pickup_delay;
		logic [TIME_W-1:0] reset_delay;
	} setting_group_s;

	typedef struct packed
	{
		logic function_enable;
		logic events_enable;
		target_mode_e target_mode;
		logic group_dependent_class;
	} common_setting_s;

endpackage

// ==== core/protection_element_comparator.sv ====
// Protection element: source forming, comparator, timers, targets and events
`timescale 1ns/1ns

// What this block does
// - Output one while input inside pickup range
// - Separate pickup and operate flags
// - Six setting groups, active one governs
// - Control class ignores active setting group
// - Operates only when function enabled; default disabled
// - Programmable on-delay before operate
// - Programmable off-delay holds operate after dropout
// - Outputs zero until run; run low resets (code keeps a set latched target standing while run is low)
// - Block input inhibits through run
// - Target disabled gives no message or lamp
// - Self-reset target follows operate state
// - Latched target holds until reset command
// - Events only when enabled: pickup, dropout, operate
// - Dropout event when pickup falls, even holding
// - Currents rescaled to common ratio before summing
// - Base is larger-ratio transformer rated current
// - Current pickup referenced to transformer rating
// - Source groups selectable currents and voltages
module protection_element_comparator
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire element_pkg::measurement_s measurement,
	input wire element_pkg::source_s source,
	input wire element_pkg::common_setting_s common,
	input wire element_pkg::setting_group_s [element_pkg::GROUP_COUNT-1:0] groups,
	input wire logic [element_pkg::GROUP_SEL_W-1:0] active_group,
	input wire logic block,
	input wire logic reset_command,
	output logic pickup_flag,
	output logic operate_flag,
	output logic target_message,
	output logic target_lamp,
	output logic pickup_event_tag,
	output logic dropout_event_tag,
	output logic operate_event_tag,
	output logic run_status
);

	// ***************************************************************
	// Setting group selection
	// ***************************************************************
	logic [element_pkg::GROUP_SEL_W-1:0] group_index;
	element_pkg::setting_group_s active_settings;

	always_comb
	begin
		group_index = element_pkg::FIRST_GROUP;
		if (common.group_dependent_class && active_group < 3'(element_pkg::GROUP_COUNT))
		begin
			group_index = active_group;
		end
		active_settings = groups[group_index];
	end

	// ***************************************************************
	// Source forming and ratio matching
	// ***************************************************************
	logic [element_pkg::RATIO_W-1:0] ratio_a;
	logic [element_pkg::RATIO_W-1:0] ratio_b;
	logic [element_pkg::RATIO_W-1:0] ratio_base;
	logic [element_pkg::MAG_W-1:0] current_a;
	logic [element_pkg::MAG_W-1:0] current_b;
	logic [32:0] primary_sum;
	logic [32:0] primary_threshold;
	logic [element_pkg::MAG_W-1:0] direct_value;
	logic direct_present;
	logic above_pickup;
	logic in_range;

	always_comb
	begin
		current_a = source.use_bank_a ? measurement.bank_a_current : 16'h0000;
		current_b = source.use_bank_b ? measurement.bank_b_current : 16'h0000;
		ratio_a = source.use_bank_a ? source.bank_a_ratio : 16'h0000;
		ratio_b = source.use_bank_b ? source.bank_b_ratio : 16'h0000;
		ratio_base = (ratio_a >= ratio_b) ? ratio_a : ratio_b;
		// Each secondary magnitude is carried to primary before the addition
		primary_sum = 33'(current_a * ratio_a) + 33'(current_b * ratio_b);
		// Pickup in per unit of the larger rated transformer
		primary_threshold = 33'(active_settings.pickup * ratio_base);
		direct_value = 16'h0000;
		direct_present = 1'b0;
		case (source.quantity)
			element_pkg::QTY_GROUND_CURRENT:
			begin
				direct_value = measurement.ground_current;
				direct_present = source.use_ground;
			end
			element_pkg::QTY_PHASE_VOLTAGE:
			begin
				direct_value = measurement.phase_voltage;
				direct_present = source.use_phase_voltage;
			end
			element_pkg::QTY_AUX_VOLTAGE:
			begin
				direct_value = measurement.aux_voltage;
				direct_present = source.use_aux_voltage;
			end
			default:
			begin
				direct_value = 16'h0000;
				direct_present = 1'b0;
			end
		endcase
		if (source.quantity == element_pkg::QTY_PHASE_CURRENT)
		begin
			above_pickup = (ratio_base != 16'h0000) && (primary_sum >= primary_threshold);
		end
		else
		begin
			above_pickup = direct_present && (direct_value >= active_settings.pickup);
		end
		// Under mode picks up below the setting, only on a present quantity
		if (active_settings.under_mode)
		begin
			if (source.quantity == element_pkg::QTY_PHASE_CURRENT)
			begin
				in_range = (ratio_base != 16'h0000) && !above_pickup;
			end
			else
			begin
				in_range = direct_present && !above_pickup;
			end
		end
		else
		begin
			in_range = above_pickup;
		end
	end

	// ***************************************************************
	// Run supervision
	// ***************************************************************
	logic run;

	assign run = common.function_enable && !block;

	// ***************************************************************
	// Pickup and operate timing
	// ***************************************************************
	element_pkg::element_state_e state_reg;
	element_pkg::element_state_e state_next;
	logic [element_pkg::TIME_W-1:0] count_reg;
	logic [element_pkg::TIME_W-1:0] count_next;
	logic [element_pkg::TIME_W-1:0] count_inc;

	assign count_inc = count_reg + element_pkg::COUNT_STEP;

	always_comb
	begin
		state_next = state_reg;
		count_next = count_reg;
		if (!run)
		begin
			state_next = element_pkg::ST_IDLE;
			count_next = element_pkg::COUNT_RESET;
		end
		else
		begin
			case (state_reg)
				element_pkg::ST_IDLE:
				begin
					count_next = element_pkg::COUNT_RESET;
					if (in_range)
					begin
						state_next = element_pkg::ST_PICKUP;
					end
				end
				element_pkg::ST_PICKUP:
				begin
					if (!in_range)
					begin
						state_next = element_pkg::ST_IDLE;
						count_next = element_pkg::COUNT_RESET;
					end
					else if (count_reg >= active_settings.pickup_delay)
					begin
						state_next = element_pkg::ST_OPERATE;
						count_next = element_pkg::COUNT_RESET;
					end
					else
					begin
						count_next = count_inc;
					end
				end
				element_pkg::ST_OPERATE:
				begin
					count_next = element_pkg::COUNT_RESET;
					if (!in_range)
					begin
						if (active_settings.reset_delay == element_pkg::COUNT_RESET)
						begin
							state_next = element_pkg::ST_IDLE;
						end
						else
						begin
							state_next = element_pkg::ST_HOLD;
						end
					end
				end
				element_pkg::ST_HOLD:
				begin
					if (in_range)
					begin
						state_next = element_pkg::ST_OPERATE;
						count_next = element_pkg::COUNT_RESET;
					end
					else if (count_inc >= active_settings.reset_delay)
					begin
						state_next = element_pkg::ST_IDLE;
						count_next = element_pkg::COUNT_RESET;
					end
					else
					begin
						count_next = count_inc;
					end
				end
				default:
				begin
					state_next = element_pkg::ST_IDLE;
					count_next = element_pkg::COUNT_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= element_pkg::ST_IDLE;
			count_reg <= element_pkg::COUNT_RESET;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	// ***************************************************************
	// Flags, targets and events
	// ***************************************************************
	logic pickup_reg;
	logic pickup_next;
	logic operate_reg;
	logic operate_next;
	logic latch_reg;
	logic latch_next;
	logic target_reg;
	logic target_next;
	logic pickup_evt_reg;
	logic pickup_evt_next;
	logic dropout_evt_reg;
	logic dropout_evt_next;
	logic operate_evt_reg;
	logic operate_evt_next;
	logic run_reg;
	logic run_next;

	always_comb
	begin
		pickup_next = (state_next == element_pkg::ST_PICKUP) || (state_next == element_pkg::ST_OPERATE);
		operate_next = (state_next == element_pkg::ST_OPERATE) || (state_next == element_pkg::ST_HOLD);
		run_next = run;
		latch_next = latch_reg;
		if (reset_command)
		begin
			latch_next = 1'b0;
		end
		// A fresh operate in the clearing cycle keeps the latch set
		if (operate_next && common.target_mode == element_pkg::TARGET_LATCHED)
		begin
			latch_next = 1'b1;
		end
		if (common.target_mode != element_pkg::TARGET_LATCHED)
		begin
			latch_next = 1'b0;
		end
		case (common.target_mode)
			element_pkg::TARGET_SELF_RESET: target_next = operate_next;
			element_pkg::TARGET_LATCHED: target_next = latch_next;
			default: target_next = 1'b0;
		endcase
		pickup_evt_next = common.events_enable && pickup_next && !pickup_reg;
		dropout_evt_next = common.events_enable && !pickup_next && pickup_reg;
		operate_evt_next = common.events_enable && operate_next && !operate_reg;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pickup_reg <= 1'b0;
			operate_reg <= 1'b0;
			latch_reg <= 1'b0;
			target_reg <= 1'b0;
			pickup_evt_reg <= 1'b0;
			dropout_evt_reg <= 1'b0;
			operate_evt_reg <= 1'b0;
			run_reg <= 1'b0;
		end
		else if (ce)
		begin
			pickup_reg <= pickup_next;
			operate_reg <= operate_next;
			latch_reg <= latch_next;
			target_reg <= target_next;
			pickup_evt_reg <= pickup_evt_next;
			dropout_evt_reg <= dropout_evt_next;
			operate_evt_reg <= operate_evt_next;
			run_reg <= run_next;
		end
	end

	assign pickup_flag = pickup_reg;
	assign operate_flag = operate_reg;
	assign target_message = target_reg;
	assign target_lamp = target_reg;
	assign pickup_event_tag = pickup_evt_reg;
	assign dropout_event_tag = dropout_evt_reg;
	assign operate_event_tag = operate_evt_reg;
	assign run_status = run_reg;

endmodule

// ==== testbench/element_asserts.sv ====
// Port assertions for the protection element comparator
`timescale 1ns/1ns
module element_asserts
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire element_pkg::common_setting_s common,
	input wire logic block,
	input wire logic reset_command,
	input wire logic pickup_flag,
	input wire logic operate_flag,
	input wire logic target_message,
	input wire logic target_lamp,
	input wire logic pickup_event_tag,
	input wire logic dropout_event_tag,
	input wire logic operate_event_tag,
	input wire logic run_status
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	logic run;
	logic ev;
	logic keep;
	logic any_event;
	logic [1:0] mode;
	assign run = common.function_enable && !block;
	assign ev = ce && common.events_enable;
	assign mode = common.target_mode;
	assign keep = ce && mode == 2'h2 && !reset_command;
	assign any_event = pickup_event_tag || dropout_event_tag || operate_event_tag;
	a_run_copy: assert property (ce |=> run_status == $past(run)) else $error("run copy");
	a_run_idle: assert property (ce && !run |=> !pickup_flag && !operate_flag) else $error("not idle");
	a_target_off: assert property (ce && mode == 2'h0 |=> !target_message && !target_lamp) else $error("tgt");
	a_self_track: assert property (ce && mode == 2'h1 |=> target_lamp == operate_flag) else $error("self");
	a_latch_hold: assert property (keep && target_message |=> target_message) else $error("latch");
	a_events_off: assert property (ce && !common.events_enable |=> !any_event) else $error("events");
	a_pickup_evt: assert property (ev |=> pickup_event_tag == $rose(pickup_flag)) else $error("pkp");
	a_drop_evt: assert property (ev |=> dropout_event_tag == $fell(pickup_flag)) else $error("dpo");
	a_op_evt: assert property (ev |=> operate_event_tag == $rose(operate_flag)) else $error("op");
	a_op_cause: assert property ($rose(operate_flag) |-> $past(pickup_flag)) else $error("early op");
	c_operate: cover property ($rose(operate_flag));
	c_drop_held: cover property (dropout_event_tag && operate_flag);
	c_latched: cover property (target_message && !operate_flag);
endmodule
bind protection_element_comparator element_asserts chk (.clk, .rst, .ce, .common, .block, .reset_command,
	.pickup_flag, .operate_flag, .target_message, .target_lamp, .pickup_event_tag, .dropout_event_tag,
	.operate_event_tag, .run_status);

// ==== testbench/meas_model.sv ====
// Measurement channel model: live channels follow the command, the others carry junk
`timescale 1ns/1ns
module meas_model
(
	input wire logic clk,
	input wire element_pkg::measurement_s cmd,
	input wire logic [4:0] live,
	output element_pkg::measurement_s meas
);
	logic [15:0] junk = 16'hA5C3;
	always @(negedge clk)
		junk <= junk * 16'h0005 + 16'h3B01;
	always_comb
		for (int i = 0; i < 5; i++)
			meas[i*16 +: 16] = live[i] ? cmd[i*16 +: 16] : junk ^ 16'(i);
endmodule

// ==== testbench/protection_element_comparator_bench.sv ====
// Self-checking bench for the protection element comparator
`timescale 1ns/1ns
module protection_element_comparator_bench;
	typedef struct {int cyc; logic [5:0] sig;} note_s;
	logic clk;
	logic rst;
	logic ce;
	logic block;
	logic reset_command;
	logic [2:0] active_group;
	logic [4:0] live;
	element_pkg::measurement_s cmd;
	element_pkg::measurement_s meas;
	element_pkg::source_s source;
	element_pkg::common_setting_s common;
	element_pkg::setting_group_s [element_pkg::GROUP_COUNT-1:0] groups;
	logic pickup_flag, operate_flag, target_message, target_lamp, run_status;
	logic pickup_event_tag, dropout_event_tag, operate_event_tag;
	logic ev, run, ab, reached, pf, of, t, run_exp;
	logic [1:0] tm;
	logic [15:0] p;
	logic [5:0] s, prev, sig, last;
	int errors, num_checks, cyc, seed, i, k, g, pd, r, len, c0;
	note_s notes[$];
	note_s e;
	meas_model partner (.clk, .cmd, .live, .meas);
	protection_element_comparator dut (.clk, .rst, .ce, .measurement(meas), .source, .common, .groups,
		.active_group, .block, .reset_command, .pickup_flag, .operate_flag, .target_message, .target_lamp,
		.pickup_event_tag, .dropout_event_tag, .operate_event_tag, .run_status);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task end_sim;
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
		cyc <= cyc + 1;
	// Run supervision as the rule states it, taken on each enabled edge
	always @(posedge clk or posedge rst)
		if (rst)
			run_exp <= 1'b0;
		else if (ce)
			run_exp <= common.function_enable && !block;
	// Every change of the flag set must match the oldest note
	always @(negedge clk)
		if (!rst)
		begin
			sig = {pickup_flag, operate_flag, target_message, pickup_event_tag, dropout_event_tag, operate_event_tag};
			if (sig !== last)
			begin
				e = '{-1, 6'bx};
				if (notes.size() > 0)
					e = notes.pop_front();
				check("flags", 32'(sig), 32'(e.sig));
				check("cycle", cyc, e.cyc);
				last = sig;
			end
			check("lamp", 32'(target_lamp), 32'(target_message));
			check("run", 32'(run_status), 32'(run_exp));
		end
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		block = 1'b0;
		reset_command = 1'b0;
		active_group = 3'h0;
		live = 5'h18;
		cmd = '0;
		source = '0;
		common = '0;
		groups = '0;
		last = '0;
		seed = 18986;
		source.bank_a_ratio = 16'h0002;
		source.bank_b_ratio = 16'h0001;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		for (i = 0; i < 36; i++)
		begin
			tm = 2'(i);
			ev = i % 5 != 4;
			run = i % 7 != 6;
			ab = i % 3 == 2;
			pd = $unsigned($random(seed)) % 5;
			r = $unsigned($random(seed)) % 4;
			len = 1 + $unsigned($random(seed)) % 9;
			p = 16'h0010 + 16'($unsigned($random(seed)) % 256);
			g = $unsigned($random(seed)) % 6;
			active_group = i % 8 == 7 ? 3'h7 : 3'(g);
			if (i % 8 == 7 || i % 6 == 5)
				g = 0;
			for (k = 0; k < 6; k++)
				groups[k] = '{1'b0, 16'hFFFF, 16'h0000, 16'h0000};
			groups[g] = '{1'b0, p, 16'(pd), 16'(r)};
			common = '{run || i[0], ev, element_pkg::target_mode_e'(tm), i % 6 != 5};
			block = !run && i[0];
			live = i[3:2] == 2'h0 ? 5'h18 : 5'h08 >> i[3:2];
			source.quantity = element_pkg::quantity_e'(i[3:2]);
			{source.use_bank_a, source.use_bank_b, source.use_ground} = live[4:2];
			{source.use_phase_voltage, source.use_aux_voltage} = live[1:0];
			@(negedge clk);
			c0 = cyc;
			cmd = {p, 16'h0000, p, p, p};
			prev = '0;
			reached = len >= pd + 2;
			for (k = 1; k <= len + r + 2; k++)
			begin
				pf = k <= len;
				of = reached && k >= pd + 2 && k <= len + (ab ? 0 : r);
				t = tm == 2'h1 ? of : tm == 2'h2 && reached && k >= pd + 2;
				s = {pf, of, t, ev && k == 1, ev && k == len + 1, ev && reached && k == pd + 2};
				if (run && s !== prev)
					notes.push_back('{c0 + k, s});
				prev = s;
			end
			repeat (len) @(negedge clk);
			if (ab)
				block = 1'b1;
			else
				cmd = {p - 16'h0001, 16'h0001, p - 16'h0001, p - 16'h0001, p - 16'h0001};
			repeat (r + 3) @(negedge clk);
			cmd = '0;
			block = 1'b0;
			@(negedge clk);
			// A frozen cycle must leave the latched target standing
			reset_command = 1'b1;
			ce = 1'b0;
			if (run && tm == 2'h2 && reached)
				notes.push_back('{cyc + 2, 6'h00});
			@(negedge clk);
			ce = 1'b1;
			@(negedge clk);
			reset_command = 1'b0;
			@(negedge clk);
		end
		// Under mode: picks up while the ground current sits below the setting
		groups[0] = '{1'b1, 16'h0040, 16'h0000, 16'h0000};
		common = '{1'b1, 1'b1, element_pkg::TARGET_SELF_RESET, 1'b0};
		live = 5'h04;
		source.quantity = element_pkg::QTY_GROUND_CURRENT;
		{source.use_bank_a, source.use_bank_b, source.use_ground} = 3'h1;
		{source.use_phase_voltage, source.use_aux_voltage} = 2'h0;
		block = 1'b0;
		cmd = {5{16'h0040}};
		@(negedge clk);
		c0 = cyc;
		cmd = {5{16'h003F}};
		notes.push_back('{c0 + 1, 6'h24});
		notes.push_back('{c0 + 2, 6'h39});
		notes.push_back('{c0 + 3, 6'h38});
		notes.push_back('{c0 + 4, 6'h02});
		notes.push_back('{c0 + 5, 6'h00});
		repeat (3) @(negedge clk);
		cmd = {5{16'h0040}};
		repeat (3) @(negedge clk);
		check("pending", 32'(notes.size()), 32'h0);
		end_sim();
	end
	// Far beyond the longest possible run of shots
	initial
	begin
		#2000000;
		errors++;
		end_sim();
	end
endmodule
